// [shared/bfu_map.svh]
`ifndef BFU_MAP_SVH
`define BFU_MAP_SVH

// Register byte offsets
`define BFU_ADR_OP       8'h00
`define BFU_ADR_OPERAND  8'h04
`define BFU_ADR_FLAGS    8'h08
`define BFU_ADR_IOREG    8'h0C

// Fields of the operation register
`define BFU_OP_CODE_LSB  0
`define BFU_OP_CODE_MSB  4
`define BFU_OP_IDX_LSB   8
`define BFU_OP_IDX_MSB   10
`define BFU_OP_CYC_LSB   12
`define BFU_OP_CYC_MSB   15

// Status flag bit positions
`define BFU_FLG_C        0
`define BFU_FLG_Z        1
`define BFU_FLG_N        2
`define BFU_FLG_V        3
`define BFU_FLG_S        4
`define BFU_FLG_H        5
`define BFU_FLG_T        6
`define BFU_FLG_I        7

// Reset values
`define BFU_RST_OPERAND  8'h00
`define BFU_RST_FLAGS    8'h00
`define BFU_RST_IOREG    8'h00

// Execution lengths in cycles
`define BFU_ONE_CYCLE    4'h1
`define BFU_IO_CYCLES    4'h2

`endif

// [shared/bfu_pkg.sv]
package bfu_pkg;

  // Operation codes; codes 5'h10..5'h1F are dedicated flag ops
  typedef enum logic [4:0] {
    OP_IDLE_CYCLE   = 5'h00,
    OP_IO_BIT_SET   = 5'h01,
    OP_IO_BIT_CLR   = 5'h02,
    OP_SHL_LOGICAL  = 5'h03,
    OP_SHR_LOGICAL  = 5'h04,
    OP_ROT_LEFT     = 5'h05,
    OP_ROT_RIGHT    = 5'h06,
    OP_SHR_ARITH    = 5'h07,
    OP_NIBBLE_SWAP  = 5'h08,
    OP_IDX_FLAG_SET = 5'h09,
    OP_IDX_FLAG_CLR = 5'h0A,
    OP_BIT_TO_XFER  = 5'h0B,
    OP_XFER_TO_BIT  = 5'h0C,
    OP_SLEEP        = 5'h0D,
    OP_WDOG_RESTART = 5'h0E,
    OP_CLR_CARRY    = 5'h10,
    OP_SET_CARRY    = 5'h11,
    OP_CLR_ZERO     = 5'h12,
    OP_SET_ZERO     = 5'h13,
    OP_CLR_NEG      = 5'h14,
    OP_SET_NEG      = 5'h15,
    OP_CLR_OVF      = 5'h16,
    OP_SET_OVF      = 5'h17,
    OP_CLR_SIGN     = 5'h18,
    OP_SET_SIGN     = 5'h19,
    OP_CLR_HALF     = 5'h1A,
    OP_SET_HALF     = 5'h1B,
    OP_CLR_XFER     = 5'h1C,
    OP_SET_XFER     = 5'h1D,
    OP_CLR_GIE      = 5'h1E,
    OP_SET_GIE      = 5'h1F
  } bfu_opc_e;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_IOWR = 3'b100
  } bfu_state_e;

endpackage

// [shared/bfu_shift_if.sv]
`timescale 1ns/10ps
// Operand path between the core and the shift unit
interface bfu_shift_if;
  import bfu_pkg::*;
  bfu_opc_e   op;
  logic [7:0] opd;
  logic       cin;
  logic [7:0] res;
  logic       cout;
  logic       flag_we;

  modport core (output op, output opd, output cin, input res, input cout, input flag_we);
  modport unit (input op, input opd, input cin, output res, output cout, output flag_we);
endinterface

// [logic/bfu_bit_put.sv]
`timescale 1ns/10ps
// Replaces one indexed bit of a word
module bfu_bit_put #(
  parameter int W  = 8,
  parameter int IW = 3
) (
  // Data in
  input  wire logic [W-1:0]  val_i,
  input  wire logic [IW-1:0] idx_i,
  input  wire logic          bit_i,
  // Data out
  output logic      [W-1:0]  val_o
);

  // Copy the word, then overwrite the chosen bit
  always_comb begin
    val_o        = val_i;
    val_o[idx_i] = bit_i;
  end

endmodule

// [logic/bfu_shifter.sv]
`timescale 1ns/10ps
// Shift, rotate and nibble swap unit
module bfu_shifter (
  // Operand and result
  bfu_shift_if.unit sh
);
  import bfu_pkg::*;

  // Result and carry out per operation
  always_comb begin
    sh.res     = sh.opd;
    sh.cout    = sh.cin;
    sh.flag_we = 1'b1;
    case (sh.op)
      OP_SHL_LOGICAL: begin
        sh.res  = {sh.opd[6:0], 1'b0}; // RL3
        sh.cout = sh.opd[7];
      end
      OP_SHR_LOGICAL: begin
        sh.res  = {1'b0, sh.opd[7:1]}; // RL4
        sh.cout = sh.opd[0];
      end
      OP_ROT_LEFT: begin
        sh.res  = {sh.opd[6:0], sh.cin}; // RL5
        sh.cout = sh.opd[7];
      end
      OP_ROT_RIGHT: begin
        sh.res  = {sh.cin, sh.opd[7:1]}; // RL6
        sh.cout = sh.opd[0];
      end
      OP_SHR_ARITH: begin
        sh.res  = {sh.opd[7], sh.opd[7:1]}; // RL7
        sh.cout = sh.opd[0];
      end
      OP_NIBBLE_SWAP: begin
        sh.res     = {sh.opd[3:0], sh.opd[7:4]}; // RL8
        sh.flag_we = 1'b0;
      end
      default: begin
        sh.flag_we = 1'b0;
      end
    endcase
  end

endmodule

// [logic/bfu_top.sv]
`timescale 1ns/10ps
// Summary of operation
// RL1: The I/O bit set operation forces the addressed I/O register bit to one in two cycles, flags untouched.
// RL2: The I/O bit clear operation forces the addressed I/O register bit to zero in two cycles, flags untouched.
// RL3: Logical shift left moves bits up, loads zero into bit 0, takes one cycle and updates Z, C, N and V.
// RL4: Logical shift right moves bits down, loads zero into bit 7, takes one cycle and updates Z, C, N and V.
// RL5: Rotate left puts the old carry in bit 0 and old bit 7 in carry in one cycle, updating Z, C, N and V.
// RL6: Rotate right puts the old carry in bit 7 and old bit 0 in carry in one cycle, updating Z, C, N and V.
// RL7: Arithmetic shift right shifts bits down while keeping the sign bit, in one cycle, updating Z, C, N and V.
// RL8: Nibble swap exchanges the two halves of the operand in one cycle with no flag change.
// RL9: Bit store copies one operand bit into the transfer flag in one cycle, no other flag changing.
// RL10: Bit load writes the transfer flag into one operand bit in one cycle, all else unchanged.
// RL11: Each of the eight flags has its own one-cycle set and clear operation touching only that flag.
// RL12: The sign flag has its own one-cycle set and clear operations touching only that flag.
// RL13: Sleep takes one cycle, changes no flag and pulses the sleep request output.
// RL14: Watchdog restart takes one cycle, changes no flag and pulses the watchdog restart output.
// RL15: Indexed flag set and clear pick one flag by a three-bit index and change only it in one cycle.
// RL16: The idle cycle operation takes one cycle and changes no register, I/O bit or flag.
module bfu_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core side
  output logic      [7:0]  io_reg_o,
  output logic      [7:0]  flags_o,
  output logic             busy_o,
  output logic             sleep_req_o,
  output logic             wdog_restart_o
);
  import bfu_pkg::*;
  `include "bfu_map.svh"

  bfu_shift_if sh ();

  bfu_state_e  st_q;
  bfu_opc_e    op_q;
  logic [2:0]  idx_q;
  logic [3:0]  cyc_cnt_q;
  logic [7:0]  operand_q;
  logic [7:0]  status_q;
  logic [7:0]  io_q;
  logic [7:0]  io_rd_q;
  logic [31:0] dat_q;
  logic        ack_q;
  logic        sleep_q;
  logic        wdog_q;
  logic        req;
  logic        wr_fire;
  logic        op_start;
  logic        is_io_op;
  logic [7:0]  adr_word;
  logic [31:0] rd_mux;
  logic [2:0]  flag_idx;
  logic        flag_bit;
  logic [7:0]  status_put;
  logic [7:0]  operand_put;
  logic [7:0]  io_put;

  // Bus decode
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_fire  = req & wb_we_i & ack_q;
  assign adr_word = {wb_adr_i[7:2], 2'b00};
  assign op_start = wr_fire & (adr_word == `BFU_ADR_OP) & (wb_sel_i[1:0] == 2'b11);
  assign is_io_op = (op_q == OP_IO_BIT_SET) | (op_q == OP_IO_BIT_CLR);

  // Outputs
  assign wb_dat_o       = dat_q;
  assign wb_ack_o       = ack_q;
  assign io_reg_o       = io_q;
  assign flags_o        = status_q;
  assign busy_o         = (st_q != ST_IDLE);
  assign sleep_req_o    = sleep_q;
  assign wdog_restart_o = wdog_q;

  // Shift unit operands
  assign sh.op  = op_q;
  assign sh.opd = operand_q;
  assign sh.cin = status_q[`BFU_FLG_C];

  bfu_shifter u_shifter (
    .sh (sh.unit)
  );

  // Flag selection: dedicated ops carry the index in the code
  always_comb begin
    flag_idx = idx_q;
    flag_bit = 1'b0;
    if (op_q[4]) begin
      flag_idx = op_q[3:1]; // RL11 RL12
      flag_bit = op_q[0];
    end else if (op_q == OP_BIT_TO_XFER) begin
      flag_idx = 3'(`BFU_FLG_T);
      flag_bit = operand_q[idx_q]; // RL9
    end else if (op_q == OP_IDX_FLAG_SET) begin
      flag_bit = 1'b1; // RL15
    end
  end

  bfu_bit_put #(.W(8), .IW(3)) u_flag_put (
    .val_i (status_q),
    .idx_i (flag_idx),
    .bit_i (flag_bit),
    .val_o (status_put)
  );

  bfu_bit_put #(.W(8), .IW(3)) u_opd_put (
    .val_i (operand_q),
    .idx_i (idx_q),
    .bit_i (status_q[`BFU_FLG_T]),
    .val_o (operand_put)
  );

  bfu_bit_put #(.W(8), .IW(3)) u_io_put (
    .val_i (io_rd_q),
    .idx_i (idx_q),
    .bit_i (op_q == OP_IO_BIT_SET),
    .val_o (io_put)
  );

  // Read data multiplexer
  always_comb begin
    rd_mux = 32'h00000000;
    case (adr_word)
      `BFU_ADR_OP: begin
        rd_mux[`BFU_OP_CODE_MSB:`BFU_OP_CODE_LSB] = op_q;
        rd_mux[`BFU_OP_IDX_MSB:`BFU_OP_IDX_LSB]   = idx_q;
        rd_mux[`BFU_OP_CYC_MSB:`BFU_OP_CYC_LSB]   = cyc_cnt_q;
      end
      `BFU_ADR_OPERAND: begin
        rd_mux[7:0] = operand_q;
      end
      `BFU_ADR_FLAGS: begin
        rd_mux[7:0] = status_q;
      end
      `BFU_ADR_IOREG: begin
        rd_mux[7:0] = io_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Acknowledge, held off while an operation runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q & (st_q == ST_IDLE);
      dat_q <= rd_mux;
    end
  end

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (op_start) begin
            st_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (is_io_op) begin
            st_q <= ST_IOWR; // RL1 RL2
          end else begin
            st_q <= ST_IDLE;
          end
        end
        ST_IOWR: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Operation latch and cycle count of the last operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q      <= OP_IDLE_CYCLE;
      idx_q     <= 3'h0;
      cyc_cnt_q <= 4'h0;
    end else begin
      if (op_start) begin
        op_q  <= bfu_opc_e'(wb_dat_i[`BFU_OP_CODE_MSB:`BFU_OP_CODE_LSB]);
        idx_q <= wb_dat_i[`BFU_OP_IDX_MSB:`BFU_OP_IDX_LSB];
      end
      if (st_q == ST_EXEC) begin
        cyc_cnt_q <= `BFU_ONE_CYCLE;
      end else if (st_q == ST_IOWR) begin
        cyc_cnt_q <= `BFU_IO_CYCLES;
      end
    end
  end

  // Working operand
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_q <= `BFU_RST_OPERAND;
    end else if (wr_fire && adr_word == `BFU_ADR_OPERAND && wb_sel_i[0]) begin
      operand_q <= wb_dat_i[7:0];
    end else if (st_q == ST_EXEC) begin
      case (op_q)
        OP_SHL_LOGICAL, OP_SHR_LOGICAL, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHR_ARITH, OP_NIBBLE_SWAP: begin
          operand_q <= sh.res; // RL3 RL4 RL5 RL6 RL7 RL8
        end
        OP_XFER_TO_BIT: begin
          operand_q <= operand_put; // RL10
        end
        default: begin
          operand_q <= operand_q; // RL16
        end
      endcase
    end
  end

  // Status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= `BFU_RST_FLAGS;
    end else if (wr_fire && adr_word == `BFU_ADR_FLAGS && wb_sel_i[0]) begin
      status_q <= wb_dat_i[7:0];
    end else if (st_q == ST_EXEC) begin
      if (sh.flag_we) begin
        status_q[`BFU_FLG_C] <= sh.cout; // RL3 RL4 RL5 RL6 RL7
        status_q[`BFU_FLG_Z] <= (sh.res == 8'h00);
        status_q[`BFU_FLG_N] <= sh.res[7];
        status_q[`BFU_FLG_V] <= sh.res[7] ^ sh.cout;
      end else if (op_q[4] || op_q == OP_IDX_FLAG_SET || op_q == OP_IDX_FLAG_CLR
                   || op_q == OP_BIT_TO_XFER) begin
        status_q <= status_put; // RL9 RL11 RL12 RL15
      end
    end
  end

  // I/O register: read in the first cycle, written back in the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_q    <= `BFU_RST_IOREG;
      io_rd_q <= `BFU_RST_IOREG;
    end else begin
      if (st_q == ST_EXEC) begin
        io_rd_q <= io_q;
      end
      if (wr_fire && adr_word == `BFU_ADR_IOREG && wb_sel_i[0]) begin
        io_q <= wb_dat_i[7:0];
      end else if (st_q == ST_IOWR) begin
        io_q <= io_put; // RL1 RL2
      end
    end
  end

  // Sleep and watchdog request pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_q <= 1'b0;
      wdog_q  <= 1'b0;
    end else begin
      sleep_q <= (st_q == ST_EXEC) && (op_q == OP_SLEEP); // RL13
      wdog_q  <= (st_q == ST_EXEC) && (op_q == OP_WDOG_RESTART); // RL14
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Result, flag and timing checks per operation
  io_set_bit_a: assert property ((st_q == ST_EXEC && op_q == OP_IO_BIT_SET) |-> ##2 // RL1
    (io_q == ($past(io_q, 2) | 8'(8'h01 << idx_q))) && st_q == ST_IDLE && $stable(status_q))
    else $error("I/O bit set wrong");
  io_clr_bit_a: assert property ((st_q == ST_EXEC && op_q == OP_IO_BIT_CLR) |-> ##2 // RL2
    (io_q == ($past(io_q, 2) & ~8'(8'h01 << idx_q))) && st_q == ST_IDLE && $stable(status_q))
    else $error("I/O bit clear wrong");
  shl_result_a: assert property ((st_q == ST_EXEC && op_q == OP_SHL_LOGICAL) |=> // RL3
    operand_q == {$past(operand_q[6:0]), 1'b0} && status_q[`BFU_FLG_C] == $past(operand_q[7])
    && st_q == ST_IDLE) else $error("Shift left wrong");
  shr_result_a: assert property ((st_q == ST_EXEC && op_q == OP_SHR_LOGICAL) |=> // RL4
    operand_q == {1'b0, $past(operand_q[7:1])} && status_q[`BFU_FLG_N] == 1'b0
    && status_q[`BFU_FLG_C] == $past(operand_q[0])) else $error("Shift right wrong");
  rol_carry_a: assert property ((st_q == ST_EXEC && op_q == OP_ROT_LEFT) |=> // RL5
    operand_q[0] == $past(status_q[`BFU_FLG_C]) && status_q[`BFU_FLG_C] == $past(operand_q[7]))
    else $error("Rotate left wrong");
  ror_carry_a: assert property ((st_q == ST_EXEC && op_q == OP_ROT_RIGHT) |=> // RL6
    operand_q[7] == $past(status_q[`BFU_FLG_C]) && status_q[`BFU_FLG_C] == $past(operand_q[0]))
    else $error("Rotate right wrong");
  asr_sign_a: assert property ((st_q == ST_EXEC && op_q == OP_SHR_ARITH) |=> // RL7
    operand_q[7] == $past(operand_q[7]) && status_q[`BFU_FLG_Z] == (operand_q == 8'h00))
    else $error("Arithmetic shift wrong");
  swap_nibble_a: assert property ((st_q == ST_EXEC && op_q == OP_NIBBLE_SWAP) |=> // RL8
    operand_q == {$past(operand_q[3:0]), $past(operand_q[7:4])} && $stable(status_q))
    else $error("Nibble swap wrong");
  bit_store_a: assert property ((st_q == ST_EXEC && op_q == OP_BIT_TO_XFER) |=> // RL9
    status_q[`BFU_FLG_T] == $past(operand_q[idx_q]) && status_q[5:0] == $past(status_q[5:0])
    && status_q[7] == $past(status_q[7])) else $error("Bit store wrong");
  bit_load_a: assert property ((st_q == ST_EXEC && op_q == OP_XFER_TO_BIT) |=> // RL10
    operand_q[idx_q] == status_q[`BFU_FLG_T] && $stable(status_q)
    && (operand_q & ~8'(8'h01 << idx_q)) == ($past(operand_q) & ~8'(8'h01 << idx_q)))
    else $error("Bit load wrong");
  own_flag_a: assert property ((st_q == ST_EXEC && op_q[4]) |=> // RL11 RL12
    status_q[$past(op_q[3:1])] == $past(op_q[0]) && $stable(operand_q)) else $error("Flag op wrong");
  idx_flag_a: assert property ((st_q == ST_EXEC && op_q == OP_IDX_FLAG_CLR) |=> // RL15
    status_q == ($past(status_q) & ~8'(8'h01 << idx_q))) else $error("Indexed clear wrong");
  sleep_pulse_a: assert property ((st_q == ST_EXEC && op_q == OP_SLEEP) |=> // RL13
    sleep_req_o && $stable(status_q) ##1 !sleep_req_o) else $error("Sleep pulse wrong");
  wdog_pulse_a: assert property ((st_q == ST_EXEC && op_q == OP_WDOG_RESTART) |=> // RL14
    wdog_restart_o && $stable(status_q) ##1 !wdog_restart_o) else $error("Watchdog pulse wrong");
  idle_keep_a: assert property ((st_q == ST_EXEC && op_q == OP_IDLE_CYCLE) |=> // RL16
    $stable(operand_q) && $stable(status_q) && $stable(io_q) && st_q == ST_IDLE)
    else $error("Idle cycle changed state");

  // Bit bodies, flag side effects and pulse sources
  rol_body_a: assert property ((st_q == ST_EXEC && op_q == OP_ROT_LEFT) |=> // RL5
    operand_q[7:1] == $past(operand_q[6:0])) else $error("Rotate left body wrong");
  ror_body_a: assert property ((st_q == ST_EXEC && op_q == OP_ROT_RIGHT) |=> // RL6
    operand_q[6:0] == $past(operand_q[7:1])) else $error("Rotate right body wrong");
  asr_carry_a: assert property ((st_q == ST_EXEC && op_q == OP_SHR_ARITH) |=> // RL7
    operand_q[6:0] == $past(operand_q[7:1]) && status_q[`BFU_FLG_C] == $past(operand_q[0]))
    else $error("Arithmetic shift carry wrong");
  shift_flags_a: assert property ((st_q == ST_EXEC && sh.flag_we) |=> // RL3 RL4 RL5 RL6 RL7
    status_q[`BFU_FLG_Z] == (operand_q == 8'h00) && status_q[`BFU_FLG_N] == operand_q[7]
    && status_q[`BFU_FLG_V] == (operand_q[7] ^ status_q[`BFU_FLG_C]) && status_q[7:4] == $past(status_q[7:4]))
    else $error("Shift flags wrong");
  own_flag_only_a: assert property ((st_q == ST_EXEC && op_q[4]) |=> // RL11 RL12
    ((status_q ^ $past(status_q)) & ~8'(8'h01 << $past(op_q[3:1]))) == 8'h00)
    else $error("Flag op touched other flags");
  idx_set_a: assert property ((st_q == ST_EXEC && op_q == OP_IDX_FLAG_SET) |=> // RL15
    status_q == ($past(status_q) | 8'(8'h01 << idx_q)) && $stable(operand_q)) else $error("Indexed set wrong");
  io_two_cycle_a: assert property ((st_q == ST_EXEC && is_io_op) |=> // RL1 RL2
    st_q == ST_IOWR && busy_o) else $error("I/O op not two cycles");
  sleep_source_a: assert property (sleep_req_o |-> // RL13
    $past(st_q == ST_EXEC && op_q == OP_SLEEP)) else $error("Sleep pulse without sleep op");
  wdog_source_a: assert property (wdog_restart_o |-> // RL14
    $past(st_q == ST_EXEC && op_q == OP_WDOG_RESTART)) else $error("Watchdog pulse without restart op");

endmodule

// [tb/bfu_top_test.sv]
`timescale 1ns/10ps
`include "bfu_map.svh"
module bfu_top_test;
  import bfu_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  io_reg_o;
  logic [7:0]  flags_o;
  logic        busy_o;
  logic        sleep_req_o;
  logic        wdog_restart_o;
  int          failures;
  int          checked;
  logic [31:0] rdat;
  logic [7:0]  pat_o [4] = '{8'h96, 8'h81, 8'h80, 8'h01};
  logic [7:0]  pat_f [4] = '{8'h5A, 8'hA5, 8'h00, 8'hFF};
  logic [7:0]  pat_i [4] = '{8'hC3, 8'h3C, 8'hFF, 8'h00};

  bfu_top i_dut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .io_reg_o       (io_reg_o),
    .flags_o        (flags_o),
    .busy_o         (busy_o),
    .sleep_req_o    (sleep_req_o),
    .wdog_restart_o (wdog_restart_o)
  );

  // Free-running 20 MHz clock
  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  // Verdict and end of run
  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One classic cycle, returns at the ack edge with the request released
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    @(posedge clk_i);
    // Only the watchdog ends a wait that never sees ack
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Write and read with the mandatory idle cycle after
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] d;
    wb_xfer(1'b1, adr, sel, dat, d);
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    wb_xfer(1'b0, adr, 4'hF, 32'h0, d);
    @(posedge clk_i);
  endtask

  // Expected operand, flags and I/O register after one operation
  function automatic logic [23:0] model(input logic [4:0] opc, input logic [2:0] idx,
                                        input logic [7:0] o, input logic [7:0] f, input logic [7:0] i);
    logic [7:0] r;
    logic       c;
    r = o;
    c = f[`BFU_FLG_C];
    case (opc)
      OP_IO_BIT_SET:   i[idx] = 1'b1;
      OP_IO_BIT_CLR:   i[idx] = 1'b0;
      OP_SHL_LOGICAL:  {c, r} = {o, 1'b0};
      OP_SHR_LOGICAL:  {r, c} = {1'b0, o};
      OP_ROT_LEFT:     {c, r} = {o, f[`BFU_FLG_C]};
      OP_ROT_RIGHT:    {r, c} = {f[`BFU_FLG_C], o};
      OP_SHR_ARITH:    {r, c} = {o[7], o};
      OP_NIBBLE_SWAP:  r = {o[3:0], o[7:4]};
      OP_IDX_FLAG_SET: f[idx] = 1'b1;
      OP_IDX_FLAG_CLR: f[idx] = 1'b0;
      OP_BIT_TO_XFER:  f[`BFU_FLG_T] = o[idx];
      OP_XFER_TO_BIT:  r[idx] = f[`BFU_FLG_T];
      default:         if (opc[4]) f[opc[3:1]] = opc[0];
    endcase
    // Shifts refresh V, N, Z and C only
    if (opc inside {[5'h03:5'h07]}) f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {r, f, i};
  endfunction

  // Load state, issue one operation, watch timing and pulses, read back
  task automatic run_op(input logic [4:0] opc, input logic [2:0] idx,
                        input logic [7:0] o, input logic [7:0] f, input logic [7:0] i);
    logic [23:0] e;
    logic [31:0] d;
    logic [3:0]  cyc;
    int          nb;
    int          ns;
    int          nw;
    e = model(opc, idx, o, f, i);
    cyc = (opc == 5'h01 || opc == 5'h02) ? `BFU_IO_CYCLES : `BFU_ONE_CYCLE;
    nb = 0;
    ns = 0;
    nw = 0;
    wr(`BFU_ADR_OPERAND, {24'h0, o}, 4'hF);
    wr(`BFU_ADR_FLAGS, {24'h0, f}, 4'hF);
    wr(`BFU_ADR_IOREG, {24'h0, i}, 4'hF);
    wb_xfer(1'b1, `BFU_ADR_OP, 4'hF, {21'h0, idx, 3'h0, opc}, d);
    repeat (4) begin
      @(posedge clk_i);
      if (busy_o === 1'b1) nb++;
      if (sleep_req_o === 1'b1) ns++;
      if (wdog_restart_o === 1'b1) nw++;
    end
    check(32'(nb), 32'(cyc));
    check(32'(ns), {31'h0, opc == OP_SLEEP});
    check(32'(nw), {31'h0, opc == OP_WDOG_RESTART});
    check({24'h0, flags_o}, {24'h0, e[15:8]});
    check({24'h0, io_reg_o}, {24'h0, e[7:0]});
    rd(`BFU_ADR_OPERAND, d);
    check(d, {24'h0, e[23:16]});
    rd(`BFU_ADR_OP, d);
    check({20'h0, d[15:12], d[10:8], d[4:0]}, {20'h0, cyc, idx, opc});
  endtask

  // Main sequence
  initial begin
    failures = 0;
    checked  = 0;
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and refused accesses
    for (int a = 0; a < 4; a++) begin
      rd(8'(a * 4), rdat);
      check(rdat, 32'h0);
    end
    wr(8'h10, 32'hFF, 4'hF);
    rd(8'h10, rdat);
    check(rdat, 32'h0);
    wr(`BFU_ADR_FLAGS, 32'hFF, 4'h2);
    check({24'h0, flags_o}, 32'h0);
    wr(`BFU_ADR_OP, 32'h0301, 4'h1);
    check({31'h0, busy_o}, 32'h0);
    check({24'h0, io_reg_o}, 32'h0);
    // Every code over four operand patterns with rotating index
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 32; k++) begin
        if (k != 15) run_op(5'(k), 3'(k + s * 3), pat_o[s], pat_f[s], pat_i[s]);
      end
    end
    // Read issued straight after an I/O op stalls until the write-back lands
    wr(`BFU_ADR_IOREG, 32'h00, 4'hF);
    wb_xfer(1'b1, `BFU_ADR_OP, 4'hF, 32'h0701, rdat);
    @(posedge clk_i);
    rd(`BFU_ADR_IOREG, rdat);
    check(rdat, 32'h80);
    complete_run();
  end

  // Watchdog against a hung handshake
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
endmodule
